// file: ubsat_pkg.sv
// shared constants for the break sequencing and branch trace block
package ubsat_pkg;
	localparam int AW = 32;
	localparam int DW = 32;
	localparam int TDEPTH = 8;
	localparam int PW = 3;
	localparam int CW = 4;
	localparam int RAW = 8;
	// register byte offsets
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_COUNT = 8'h04;
	localparam logic [7:0] OFF_A_ADDR = 8'h08;
	localparam logic [7:0] OFF_A_MASK = 8'h0C;
	localparam logic [7:0] OFF_A_CYC = 8'h10;
	localparam logic [7:0] OFF_B_ADDR = 8'h14;
	localparam logic [7:0] OFF_B_MASK = 8'h18;
	localparam logic [7:0] OFF_B_CYC = 8'h1C;
	localparam logic [7:0] OFF_B_DATA = 8'h20;
	localparam logic [7:0] OFF_B_DMASK = 8'h24;
	localparam logic [7:0] OFF_SPC = 8'h28;
	localparam logic [7:0] OFF_TSRC = 8'h2C;
	localparam logic [7:0] OFF_TDST = 8'h30;
	localparam logic [7:0] OFF_STAT = 8'h34;
	// control register bits
	localparam int CTRL_SEQ = 0;
	localparam int CTRL_TRACE = 1;
	localparam int CTRL_COUNT = 2;
	// cycle select bits
	localparam int CYC_FETCH = 0;
	localparam int CYC_WRITE = 1;
	localparam int CYC_SYSBUS = 2;
	localparam int CYC_PRE = 3;
	localparam int CYC_DATA = 4;
	localparam int CYC_W = 5;
	// status register bits
	localparam int STAT_A = 0;
	localparam int STAT_B = 1;
	localparam int STAT_ARM = 2;
	localparam int STAT_CNT = 4;
	localparam int CNT_W = 16;
	localparam logic [CNT_W-1:0] COUNT_ONE = 16'h0001;
	localparam logic [CW-1:0] TFULL = 4'h8;
	localparam logic [CW-1:0] CNT_ZERO = 4'h0;
	localparam logic [DW-1:0] RST_WORD = 32'h0000_0000;
	// arm state of the two step break
	typedef enum logic {UBSAT_IDLE, UBSAT_ARMED} ubsat_arm_t;
endpackage

// file: ubsat_trace_mem.sv
// eight pair branch trace storage with registered read port
`timescale 1ns/10ps
module ubsat_trace_mem (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic wr_en,
	input wire logic [ubsat_pkg::PW-1:0] wr_addr,
	input wire logic [2*ubsat_pkg::AW-1:0] wr_data,
	input wire logic [ubsat_pkg::PW-1:0] rd_addr,
	output logic [2*ubsat_pkg::AW-1:0] rd_data
);
	// array holds no reset, its contents are undefined until written
	logic [2*ubsat_pkg::AW-1:0] mem [ubsat_pkg::TDEPTH];

	////////////////////////////////////////////////////////////////
	// write port
	always_ff @(posedge clk_sys) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	// read port, one cycle behind the address
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rd_data <= '0;
		end else begin
			rd_data <= mem[rd_addr];
		end
	end
endmodule

// file: ubsat_chan_match.sv
// one break channel comparator over both observed buses
`timescale 1ns/10ps
module ubsat_chan_match (
	input wire logic [ubsat_pkg::AW-1:0] cmp_addr,
	input wire logic [ubsat_pkg::AW-1:0] cmp_mask,
	input wire logic [ubsat_pkg::CYC_W-1:0] cyc_sel,
	input wire logic [ubsat_pkg::DW-1:0] cmp_data,
	input wire logic [ubsat_pkg::DW-1:0] cmp_dmask,
	input wire logic lb_valid,
	input wire logic [ubsat_pkg::AW-1:0] lb_addr,
	input wire logic lb_fetch,
	input wire logic lb_write,
	input wire logic [ubsat_pkg::DW-1:0] lb_data,
	input wire logic ib_valid,
	input wire logic [ubsat_pkg::AW-1:0] ib_addr,
	input wire logic ib_fetch,
	input wire logic ib_write,
	input wire logic [ubsat_pkg::DW-1:0] ib_data,
	output logic hit
);
	// bus chosen by the channel's own select bit
	wire sys = cyc_sel[ubsat_pkg::CYC_SYSBUS];
	wire b_valid = sys ? ib_valid : lb_valid;
	wire [ubsat_pkg::AW-1:0] b_addr = sys ? ib_addr : lb_addr;
	wire b_fetch = sys ? ib_fetch : lb_fetch;
	wire b_write = sys ? ib_write : lb_write;
	wire [ubsat_pkg::DW-1:0] b_data = sys ? ib_data : lb_data;
	wire want_fetch = cyc_sel[ubsat_pkg::CYC_FETCH];
	wire want_write = cyc_sel[ubsat_pkg::CYC_WRITE];
	// masked bits take no part in the compare
	wire addr_ok = ((b_addr ^ cmp_addr) & ~cmp_mask) == '0;
	// data compare only on data cycles; fetch ignores it
	wire data_use = cyc_sel[ubsat_pkg::CYC_DATA] & ~want_fetch;
	wire data_ok = ~data_use | (((b_data ^ cmp_data) & ~cmp_dmask) == '0);
	// fetches are reads at even addresses only
	wire never = want_fetch & (want_write | cmp_addr[0]);
	wire kind_ok = (b_fetch == want_fetch) & (b_write == want_write);

	assign hit = b_valid & addr_ok & data_ok & kind_ok & ~never;
endmodule

// file: ubsat_top.sv
// break sequencing, restart address and branch trace queue
`timescale 1ns/10ps
module ubsat_top (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [ubsat_pkg::RAW-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [ubsat_pkg::DW-1:0] wb_dat_i,
	output logic [ubsat_pkg::DW-1:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic lb_valid,
	input wire logic [ubsat_pkg::AW-1:0] lb_addr,
	input wire logic lb_fetch,
	input wire logic lb_write,
	input wire logic [ubsat_pkg::DW-1:0] lb_data,
	input wire logic ib_valid,
	input wire logic [ubsat_pkg::AW-1:0] ib_addr,
	input wire logic ib_fetch,
	input wire logic ib_write,
	input wire logic [ubsat_pkg::DW-1:0] ib_data,
	input wire logic [ubsat_pkg::AW-1:0] cur_pc,
	input wire logic [ubsat_pkg::AW-1:0] cur_next_pc,
	input wire logic cur_in_slot,
	input wire logic [ubsat_pkg::AW-1:0] cur_branch_pc,
	input wire logic flow_valid,
	input wire logic [ubsat_pkg::AW-1:0] flow_src,
	input wire logic [ubsat_pkg::AW-1:0] flow_dst,
	output logic brk_req,
	output logic [ubsat_pkg::AW-1:0] brk_spc
);
	// software visible registers
	logic [2:0] break_control_register; // sequential, trace, count enables
	logic [ubsat_pkg::CNT_W-1:0] execution_count_register;
	logic [ubsat_pkg::AW-1:0] chan_a_compare_address;
	logic [ubsat_pkg::AW-1:0] chan_a_address_mask;
	logic [ubsat_pkg::CYC_W-1:0] chan_a_cycle_select;
	logic [ubsat_pkg::AW-1:0] chan_b_compare_address;
	logic [ubsat_pkg::AW-1:0] chan_b_address_mask;
	logic [ubsat_pkg::CYC_W-1:0] chan_b_cycle_select;
	logic [ubsat_pkg::DW-1:0] chan_b_compare_data;
	logic [ubsat_pkg::DW-1:0] chan_b_data_mask;
	logic [ubsat_pkg::AW-1:0] saved_program_counter;
	logic flag_a; // sticky channel a match
	logic flag_b; // sticky channel b match
	// sequencing and trace state
	ubsat_pkg::ubsat_arm_t arm;
	ubsat_pkg::ubsat_arm_t next_arm;
	logic [ubsat_pkg::PW-1:0] wr_ptr;
	logic [ubsat_pkg::PW-1:0] rd_ptr;
	logic [ubsat_pkg::CW-1:0] tcount; // unread pairs, 0..8
	logic trace_was_on; // last cycle's trace enable
	logic [2*ubsat_pkg::AW-1:0] trace_pair;
	logic [ubsat_pkg::DW-1:0] next_rdata;
	logic a_hit;
	logic b_hit;

	////////////////////////////////////////////////////////////////
	// bus decode
	wire access = wb_cyc_i & wb_stb_i & ~wb_ack_o; // single cycle ack
	wire wr = access & wb_we_i;
	wire rd = access & ~wb_we_i;
	wire [ubsat_pkg::DW-1:0] bmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
		{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	wire [ubsat_pkg::DW-1:0] wdat = wb_dat_i & bmask;
	wire wr_ctrl = wr & (wb_adr_i == ubsat_pkg::OFF_CTRL);
	wire wr_count = wr & (wb_adr_i == ubsat_pkg::OFF_COUNT);
	wire wr_stat = wr & (wb_adr_i == ubsat_pkg::OFF_STAT);
	wire rd_dst = rd & (wb_adr_i == ubsat_pkg::OFF_TDST);
	wire seq_on = break_control_register[ubsat_pkg::CTRL_SEQ];
	wire trace_on = break_control_register[ubsat_pkg::CTRL_TRACE];
	wire count_on = break_control_register[ubsat_pkg::CTRL_COUNT];

	////////////////////////////////////////////////////////////////
	// channel comparators
	ubsat_chan_match u_chan_a (
		.cmp_addr(chan_a_compare_address),
		.cmp_mask(chan_a_address_mask),
		.cyc_sel(chan_a_cycle_select),
		.cmp_data(ubsat_pkg::RST_WORD),
		.cmp_dmask(ubsat_pkg::RST_WORD),
		.lb_valid(lb_valid),
		.lb_addr(lb_addr),
		.lb_fetch(lb_fetch),
		.lb_write(lb_write),
		.lb_data(lb_data),
		.ib_valid(ib_valid),
		.ib_addr(ib_addr),
		.ib_fetch(ib_fetch),
		.ib_write(ib_write),
		.ib_data(ib_data),
		.hit(a_hit)
	);

	ubsat_chan_match u_chan_b (
		.cmp_addr(chan_b_compare_address),
		.cmp_mask(chan_b_address_mask),
		.cyc_sel(chan_b_cycle_select),
		.cmp_data(chan_b_compare_data),
		.cmp_dmask(chan_b_data_mask),
		.lb_valid(lb_valid),
		.lb_addr(lb_addr),
		.lb_fetch(lb_fetch),
		.lb_write(lb_write),
		.lb_data(lb_data),
		.ib_valid(ib_valid),
		.ib_addr(ib_addr),
		.ib_fetch(ib_fetch),
		.ib_write(ib_write),
		.ib_data(ib_data),
		.hit(b_hit)
	);

	////////////////////////////////////////////////////////////////
	// break decision
	// a pending a match counts only in a later cycle, not alongside b
	wire armed = (arm == ubsat_pkg::UBSAT_ARMED);
	wire b_event = seq_on ? (b_hit & armed & ~a_hit) : b_hit;
	// count of one fires on the first qualifying b match
	wire count_last = execution_count_register <= ubsat_pkg::COUNT_ONE;
	wire fire_b = b_event & (~count_on | count_last);
	wire fire_a = ~seq_on & a_hit;
	wire fire = fire_a | fire_b;
	wire [ubsat_pkg::CYC_W-1:0] fire_cyc = fire_b ? chan_b_cycle_select : chan_a_cycle_select;
	wire pre_fetch = fire_cyc[ubsat_pkg::CYC_FETCH] & fire_cyc[ubsat_pkg::CYC_PRE];
	// pre-fetch: own address, or the branch when sitting in its slot
	wire [ubsat_pkg::AW-1:0] pre_pc = cur_in_slot ? cur_branch_pc : cur_pc;
	// otherwise the core's resolved next pc, already the target after a
	// branch or slot; data compare and system bus make this approximate
	// since the match may land up to two instructions late
	wire [ubsat_pkg::AW-1:0] restart_pc = pre_fetch ? pre_pc : cur_next_pc;

	// arm state: clearing the sequential bit drops a pending a match
	always_comb begin
		next_arm = arm;
		case (arm)
			ubsat_pkg::UBSAT_IDLE: begin
				if (seq_on & a_hit) begin
					next_arm = ubsat_pkg::UBSAT_ARMED;
				end
			end
			ubsat_pkg::UBSAT_ARMED: begin
				if (fire_b) begin
					next_arm = ubsat_pkg::UBSAT_IDLE;
				end
			end
			default: begin
				next_arm = ubsat_pkg::UBSAT_IDLE;
			end
		endcase
		if (~seq_on) begin
			next_arm = ubsat_pkg::UBSAT_IDLE;
		end
	end

	// arm register
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			arm <= ubsat_pkg::UBSAT_IDLE;
		end else begin
			arm <= next_arm;
		end
	end

	// break request pulse with its restart address; spc is saved in the
	// same edge so the core sees it before entering its handler
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			brk_req <= 1'b0;
			brk_spc <= ubsat_pkg::RST_WORD;
			saved_program_counter <= ubsat_pkg::RST_WORD;
		end else begin
			brk_req <= fire;
			if (fire) begin
				brk_spc <= restart_pc;
				saved_program_counter <= restart_pc;
			end
		end
	end

	// execution count: a software write wins over the hardware decrement
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			execution_count_register <= '0;
		end else if (wr_count) begin
			execution_count_register <= wdat[ubsat_pkg::CNT_W-1:0];
		end else if (count_on & b_event & ~count_last) begin
			execution_count_register <= execution_count_register - ubsat_pkg::COUNT_ONE;
		end
	end

	// sticky match flags, write one to clear, a new hit wins
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			flag_a <= 1'b0;
			flag_b <= 1'b0;
		end else begin
			flag_a <= a_hit | (flag_a & ~(wr_stat & wdat[ubsat_pkg::STAT_A]));
			flag_b <= b_hit | (flag_b & ~(wr_stat & wdat[ubsat_pkg::STAT_B]));
		end
	end

	////////////////////////////////////////////////////////////////
	// configuration registers
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			break_control_register <= '0;
			chan_a_compare_address <= ubsat_pkg::RST_WORD;
			chan_a_address_mask <= ubsat_pkg::RST_WORD;
			chan_a_cycle_select <= '0;
			chan_b_compare_address <= ubsat_pkg::RST_WORD;
			chan_b_address_mask <= ubsat_pkg::RST_WORD;
			chan_b_cycle_select <= '0;
			chan_b_compare_data <= ubsat_pkg::RST_WORD;
			chan_b_data_mask <= ubsat_pkg::RST_WORD;
		end else if (wr) begin
			case (wb_adr_i)
				ubsat_pkg::OFF_CTRL: break_control_register <= wdat[2:0];
				ubsat_pkg::OFF_A_ADDR: chan_a_compare_address <= wdat;
				ubsat_pkg::OFF_A_MASK: chan_a_address_mask <= wdat;
				ubsat_pkg::OFF_A_CYC: chan_a_cycle_select <= wdat[ubsat_pkg::CYC_W-1:0];
				ubsat_pkg::OFF_B_ADDR: chan_b_compare_address <= wdat;
				ubsat_pkg::OFF_B_MASK: chan_b_address_mask <= wdat;
				ubsat_pkg::OFF_B_CYC: chan_b_cycle_select <= wdat[ubsat_pkg::CYC_W-1:0];
				ubsat_pkg::OFF_B_DATA: chan_b_compare_data <= wdat;
				ubsat_pkg::OFF_B_DMASK: chan_b_data_mask <= wdat;
				default: begin
					// count, status, read-only or unmapped: not written here
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// branch trace queue
	wire push = flow_valid & trace_on;
	wire full = tcount == ubsat_pkg::TFULL;
	wire pop = rd_dst & (tcount != ubsat_pkg::CNT_ZERO);
	wire drop = push & full & ~pop; // oldest lost to keep newest
	wire restart_trace = trace_on & ~trace_was_on;
	wire [ubsat_pkg::CW-1:0] push_n = {3'h0, push & ~(full & ~pop)};
	wire [ubsat_pkg::CW-1:0] pop_n = {3'h0, pop};

	ubsat_trace_mem u_mem (
		.clk_sys(clk_sys),
		.rst(rst),
		.wr_en(push),
		.wr_addr(wr_ptr),
		.wr_data({flow_src, flow_dst}),
		.rd_addr(rd_ptr),
		.rd_data(trace_pair)
	);

	// pointers: re-enabling trace starts an empty queue; both halves
	// share rd_ptr and only a destination read or a drop moves it
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			tcount <= '0;
			trace_was_on <= 1'b0;
		end else begin
			trace_was_on <= trace_on;
			if (restart_trace) begin
				wr_ptr <= '0;
				rd_ptr <= '0;
				tcount <= '0;
			end else begin
				if (push) begin
					wr_ptr <= wr_ptr + 3'h1;
				end
				if (pop | drop) begin
					rd_ptr <= rd_ptr + 3'h1;
				end
				tcount <= tcount + push_n - pop_n;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// an empty queue reads as zero; the array holds no reset value, so
	// without this a read after reset or a restart would return unknown or stale pairs
	wire q_empty = (tcount == ubsat_pkg::CNT_ZERO);
	wire [ubsat_pkg::AW-1:0] tsrc_word = q_empty ? ubsat_pkg::RST_WORD
		: trace_pair[2*ubsat_pkg::AW-1:ubsat_pkg::AW];
	wire [ubsat_pkg::AW-1:0] tdst_word = q_empty ? ubsat_pkg::RST_WORD
		: trace_pair[ubsat_pkg::AW-1:0];

	// read mux; source reads leave the queue untouched
	always_comb begin
		next_rdata = ubsat_pkg::RST_WORD;
		case (wb_adr_i)
			ubsat_pkg::OFF_CTRL: next_rdata = {29'h0, break_control_register};
			ubsat_pkg::OFF_COUNT: next_rdata = {16'h0, execution_count_register};
			ubsat_pkg::OFF_A_ADDR: next_rdata = chan_a_compare_address;
			ubsat_pkg::OFF_A_MASK: next_rdata = chan_a_address_mask;
			ubsat_pkg::OFF_A_CYC: next_rdata = {27'h0, chan_a_cycle_select};
			ubsat_pkg::OFF_B_ADDR: next_rdata = chan_b_compare_address;
			ubsat_pkg::OFF_B_MASK: next_rdata = chan_b_address_mask;
			ubsat_pkg::OFF_B_CYC: next_rdata = {27'h0, chan_b_cycle_select};
			ubsat_pkg::OFF_B_DATA: next_rdata = chan_b_compare_data;
			ubsat_pkg::OFF_B_DMASK: next_rdata = chan_b_data_mask;
			ubsat_pkg::OFF_SPC: next_rdata = saved_program_counter;
			ubsat_pkg::OFF_TSRC: next_rdata = tsrc_word;
			ubsat_pkg::OFF_TDST: next_rdata = tdst_word;
			ubsat_pkg::OFF_STAT: next_rdata = {24'h0, tcount, 1'b0, armed, flag_b, flag_a};
			default: next_rdata = ubsat_pkg::RST_WORD;
		endcase
	end

	// single cycle ack; unmapped reads return zero
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= ubsat_pkg::RST_WORD;
		end else begin
			wb_ack_o <= access;
			if (rd) begin
				wb_dat_o <= next_rdata;
			end
		end
	end
endmodule

// file: ubsat_checker.sv
// concurrent checks on the register bus, break and restart address ports
`timescale 1ns/10ps
module ubsat_checker (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [ubsat_pkg::RAW-1:0] wb_adr_i,
	input wire logic [ubsat_pkg::DW-1:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic lb_valid,
	input wire logic ib_valid,
	input wire logic [ubsat_pkg::AW-1:0] cur_pc,
	input wire logic [ubsat_pkg::AW-1:0] cur_next_pc,
	input wire logic cur_in_slot,
	input wire logic [ubsat_pkg::AW-1:0] cur_branch_pc,
	input wire logic brk_req,
	input wire logic [ubsat_pkg::AW-1:0] brk_spc
);
	// everything here lives in the one system clock domain
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);
	////////////////////////////////////////////////////////////////
	property p_ack;
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
	endproperty
	a_ack: assert property (p_ack) else $error("request not answered next cycle");
	property p_ack_cause;
		wb_ack_o |-> $past(wb_cyc_i && wb_stb_i) ##1 !wb_ack_o;
	endproperty
	a_ack_cause: assert property (p_ack_cause) else $error("stray or long ack");
	property p_dat_hold;
		$changed(wb_dat_o) |-> wb_ack_o && !wb_we_i;
	endproperty
	a_dat_hold: assert property (p_dat_hold) else $error("read data moved");
	property p_spc_rd;
		wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o && wb_adr_i == ubsat_pkg::OFF_SPC
			&& !lb_valid && !ib_valid |=> wb_dat_o == brk_spc;
	endproperty
	a_spc_rd: assert property (p_spc_rd) else $error("saved pc read differs");
	property p_brk_cause;
		brk_req |-> $past(lb_valid || ib_valid);
	endproperty
	a_brk_cause: assert property (p_brk_cause) else $error("break without bus cycle");
	property p_spc_only_brk;
		$changed(brk_spc) |-> brk_req;
	endproperty
	a_spc_only_brk: assert property (p_spc_only_brk) else $error("spc moved alone");
	property p_spc_src;
		brk_req |-> brk_spc == $past(cur_pc) || brk_spc == $past(cur_next_pc)
			|| brk_spc == $past(cur_branch_pc);
	endproperty
	a_spc_src: assert property (p_spc_src) else $error("spc not a restart address");
	property p_pair;
		brk_req && !$past(cur_in_slot) && $past(cur_branch_pc) != $past(cur_pc)
			|-> brk_spc != $past(cur_branch_pc);
	endproperty
	a_pair: assert property (p_pair) else $error("branch saved outside a slot");
endmodule
bind ubsat_top ubsat_checker u_chk (.clk_sys, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i,
	.wb_adr_i, .wb_dat_o, .wb_ack_o, .lb_valid, .ib_valid, .cur_pc, .cur_next_pc,
	.cur_in_slot, .cur_branch_pc, .brk_req, .brk_spc);

// file: ubsat_core_model.sv
// core side model: observed bus cycles, restart context and flow records
`timescale 1ns/10ps
module ubsat_core_model (
	input wire logic clk_sys,
	output logic lb_valid,
	output logic [ubsat_pkg::AW-1:0] lb_addr,
	output logic lb_fetch,
	output logic lb_write,
	output logic [ubsat_pkg::DW-1:0] lb_data,
	output logic ib_valid,
	output logic [ubsat_pkg::AW-1:0] ib_addr,
	output logic ib_fetch,
	output logic ib_write,
	output logic [ubsat_pkg::DW-1:0] ib_data,
	output logic [ubsat_pkg::AW-1:0] cur_pc,
	output logic [ubsat_pkg::AW-1:0] cur_next_pc,
	output logic cur_in_slot,
	output logic [ubsat_pkg::AW-1:0] cur_branch_pc,
	output logic flow_valid,
	output logic [ubsat_pkg::AW-1:0] flow_src,
	output logic [ubsat_pkg::AW-1:0] flow_dst
);
	logic v, s; // cycle valid, system bus select
	logic [ubsat_pkg::AW-1:0] a; // cycle address, inverted once released
	// one driver feeds both buses; only the selected one shows valid
	assign lb_valid = v & ~s;
	assign ib_valid = v & s;
	assign lb_addr = a;
	assign ib_addr = a;
	assign lb_data = ~a;
	assign ib_data = ~a;
	assign ib_fetch = lb_fetch;
	assign ib_write = lb_write;
	// restart context: next is two bytes on, owning branch two bytes back
	assign cur_pc = a;
	assign cur_next_pc = a + 32'h2;
	assign cur_branch_pc = a - 32'h2;
	initial begin
		{v, s, lb_fetch, lb_write, cur_in_slot, flow_valid} = 6'h00;
		a = 32'h5A5A_A5A5;
		flow_src = 32'h0;
		flow_dst = 32'h0;
	end
	////////////////////////////////////////////////////////////////
	// one bus cycle, flags {system bus, fetch, write, slot}
	task step(input logic [3:0] k, input logic [31:0] ad);
		@(posedge clk_sys);
		v <= 1'b1;
		{s, lb_fetch, lb_write, cur_in_slot} <= k;
		a <= ad;
		@(posedge clk_sys);
		v <= 1'b0;
		a <= ~ad;
	endtask
	// back to back flow records: branch address then target, saved pc then handler
	task flows(input int n, input logic [31:0] b);
		int i;
		for (i = 0; i < n; i++) begin
			@(posedge clk_sys);
			flow_valid <= 1'b1;
			flow_src <= b + 32'(i) * 32'h10;
			flow_dst <= b + 32'(i) * 32'h10 + 32'h8;
		end
		@(posedge clk_sys);
		flow_valid <= 1'b0;
		flow_src <= ~flow_src;
		flow_dst <= ~flow_dst;
	endtask
endmodule

// file: tb.sv
// self-checking bench for break sequencing, restart address and trace queue
`timescale 1ns/10ps
module tb;
	logic clk_sys, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, brk_req;
	logic [7:0] wb_adr_i;
	logic [3:0] wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, q, brk_spc;
	logic lb_valid, lb_fetch, lb_write, ib_valid, ib_fetch, ib_write, cur_in_slot, flow_valid;
	logic [31:0] lb_addr, lb_data, ib_addr, ib_data, cur_pc, cur_next_pc, cur_branch_pc;
	logic [31:0] flow_src, flow_dst;
	int n_errors, checked;
	ubsat_top DUT (.clk_sys, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
		.wb_dat_i, .wb_dat_o, .wb_ack_o, .lb_valid, .lb_addr, .lb_fetch, .lb_write, .lb_data,
		.ib_valid, .ib_addr, .ib_fetch, .ib_write, .ib_data, .cur_pc, .cur_next_pc,
		.cur_in_slot, .cur_branch_pc, .flow_valid, .flow_src, .flow_dst, .brk_req, .brk_spc);
	ubsat_core_model core (.clk_sys, .lb_valid, .lb_addr, .lb_fetch, .lb_write, .lb_data,
		.ib_valid, .ib_addr, .ib_fetch, .ib_write, .ib_data, .cur_pc, .cur_next_pc,
		.cur_in_slot, .cur_branch_pc, .flow_valid, .flow_src, .flow_dst);
	// 250 MHz system clock
	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end
	////////////////////////////////////////////////////////////////
	task complete_run;
		if (n_errors == 0 && checked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task chk(input string n, input logic [31:0] e, input logic [31:0] s);
		checked++;
		if (s !== e) begin
			$display("MISMATCH %s expected %h seen %h", n, e, s);
			n_errors++;
		end
	endtask
	// classic cycle held until ack is sampled high; data taken at that edge
	task wb(input logic w, input logic [7:0] ad, input logic [31:0] d);
		int i;
		@(posedge clk_sys);
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, w, ad, d};
		i = 0;
		do begin
			@(posedge clk_sys);
			i++;
		end while (wb_ack_o !== 1'b1 && i < 50);
		q = wb_dat_o;
		{wb_cyc_i, wb_stb_i} <= 2'h0;
		// a lost ack ends the run rather than hanging it
		if (wb_ack_o !== 1'b1) begin
			chk("wb_ack_o", 32'h1, {31'h0, wb_ack_o});
			complete_run;
		end
	endtask
	task wr(input logic [7:0] ad, input logic [31:0] d);
		wb(1'b1, ad, d);
	endtask
	task rd(input logic [7:0] ad);
		wb(1'b0, ad, 32'h0);
	endtask
	// channel setup: compare address, mask, cycle select at base, +4, +8
	task chan(input logic [7:0] b, input logic [31:0] ad, input logic [31:0] m,
		input logic [4:0] c);
		wr(b, ad);
		wr(b + 8'h4, m);
		wr(b + 8'h8, {27'h0, c});
	endtask
	// one bus cycle then the break verdict in the following cycle
	task hit(input logic [3:0] k, input logic [31:0] ad, input logic e, input logic [31:0] p);
		core.step(k, ad);
		#1;
		chk("brk_req", {31'h0, e}, {31'h0, brk_req});
		if (e) chk("brk_spc", p, brk_spc);
	endtask
	////////////////////////////////////////////////////////////////
	task t_regs;
		int i;
		for (i = 0; i < 16; i++) begin
			rd(8'(i * 4));
			chk("reset value", 32'h0, q);
		end
		wr(ubsat_pkg::OFF_COUNT, 32'h1234);
		rd(ubsat_pkg::OFF_COUNT);
		chk("count", 32'h1234, q);
		wr(ubsat_pkg::OFF_SPC, 32'hFFFF_FFFF);
		rd(ubsat_pkg::OFF_SPC);
		chk("saved pc read only", 32'h0, q);
	endtask
	task t_restart;
		chan(8'h14, 32'h1000, 32'h6, 5'h09);
		hit(4'h5, 32'h1006, 1'b1, 32'h1004);
		hit(4'h4, 32'h1008, 1'b0, 32'h0);
		rd(ubsat_pkg::OFF_SPC);
		chk("saved pc", 32'h1004, q);
		chan(8'h14, 32'h1000, 32'h0, 5'h01);
		hit(4'h4, 32'h1000, 1'b1, 32'h1002);
		chan(8'h14, 32'h1000, 32'h0, 5'h00);
		hit(4'h1, 32'h1000, 1'b1, 32'h1002);
		// the model puts the inverted address on the data lines
		chan(8'h14, 32'h1000, 32'h0, 5'h10);
		wr(ubsat_pkg::OFF_B_DATA, 32'hFFFF_EFFF);
		hit(4'h0, 32'h1000, 1'b1, 32'h1002);
		wr(ubsat_pkg::OFF_B_DATA, 32'h0);
		hit(4'h0, 32'h1000, 1'b0, 32'h0);
		chan(8'h14, 32'h1000, 32'h0, 5'h03);
		hit(4'h6, 32'h1000, 1'b0, 32'h0);
		chan(8'h14, 32'h1001, 32'h1, 5'h09);
		hit(4'h4, 32'h1000, 1'b0, 32'h0);
	endtask
	// a covers 1000/1004, b covers 1004/100C: 1004 hits both at once
	task t_seq;
		chan(8'h08, 32'h1000, 32'h4, 5'h09);
		chan(8'h14, 32'h1004, 32'h8, 5'h09);
		wr(ubsat_pkg::OFF_CTRL, 32'h1);
		hit(4'h4, 32'h100C, 1'b0, 32'h0);
		hit(4'h4, 32'h1004, 1'b0, 32'h0);
		hit(4'h4, 32'h100C, 1'b1, 32'h100C);
		hit(4'h4, 32'h1000, 1'b0, 32'h0);
		wr(ubsat_pkg::OFF_CTRL, 32'h0);
		wr(ubsat_pkg::OFF_CTRL, 32'h1);
		hit(4'h4, 32'h100C, 1'b0, 32'h0);
	endtask
	task t_count;
		int i;
		wr(ubsat_pkg::OFF_CTRL, 32'h4);
		wr(ubsat_pkg::OFF_COUNT, 32'h5);
		for (i = 1; i <= 5; i++) hit(4'h4, 32'h100C, i == 5, 32'h100C);
		chan(8'h08, 32'h1000, 32'h4, 5'h0D);
		chan(8'h14, 32'h1004, 32'h8, 5'h0D);
		wr(ubsat_pkg::OFF_CTRL, 32'h5);
		wr(ubsat_pkg::OFF_COUNT, 32'h1);
		hit(4'hC, 32'h1000, 1'b0, 32'h0);
		hit(4'hC, 32'h100C, 1'b1, 32'h100C);
	endtask
	// nine records into eight places: the first is lost
	task t_trace;
		wr(ubsat_pkg::OFF_CTRL, 32'h0);
		core.flows(1, 32'h3000);
		rd(ubsat_pkg::OFF_STAT);
		chk("count while off", 32'h0, q & 32'hF0);
		wr(ubsat_pkg::OFF_CTRL, 32'h2);
		core.flows(9, 32'h2000);
		rd(ubsat_pkg::OFF_STAT);
		chk("count full", 32'h80, q & 32'hF0);
		rd(ubsat_pkg::OFF_TSRC);
		chk("oldest source", 32'h2010, q);
		rd(ubsat_pkg::OFF_TSRC);
		chk("source again", 32'h2010, q);
		rd(ubsat_pkg::OFF_TDST);
		chk("oldest destination", 32'h2018, q);
		rd(ubsat_pkg::OFF_TSRC);
		chk("next source", 32'h2020, q);
		rd(ubsat_pkg::OFF_STAT);
		chk("count after pop", 32'h70, q & 32'hF0);
		wr(ubsat_pkg::OFF_CTRL, 32'h0);
		wr(ubsat_pkg::OFF_CTRL, 32'h2);
		rd(ubsat_pkg::OFF_STAT);
		chk("count after toggle", 32'h0, q & 32'hF0);
		rd(ubsat_pkg::OFF_TSRC);
		chk("source after toggle", 32'h0, q);
	endtask
	////////////////////////////////////////////////////////////////
	// reset for five cycles, then each scenario in turn
	initial begin
		rst = 1'b1;
		{wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
		wb_adr_i = 8'h00;
		wb_sel_i = 4'hF;
		wb_dat_i = 32'h0;
		n_errors = 0;
		checked = 0;
		repeat (5) @(posedge clk_sys);
		rst <= 1'b0;
		t_regs;
		t_restart;
		t_seq;
		t_count;
		t_trace;
		complete_run;
	end
endmodule
